/* File: hw/gts_pkg.sv */
// constants, field layouts and carrier types for the general timer set
package gts_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_TIMERS = 9;   // index 0 standalone, 1..8 the pair timers
  localparam int NUM_PAIRS  = 4;
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 16;
  localparam int PS_W       = 8;

  // ---------------------------------------------------------------
  // register map: timer index in addr[5:2], register in addr[1:0]
  // ---------------------------------------------------------------
  localparam logic [1:0]        REG_CTRL    = 2'h0;
  localparam logic [1:0]        REG_PERIOD  = 2'h1;
  localparam logic [1:0]        REG_COUNT   = 2'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h24;
  localparam logic [3:0]        LAST_TIMER  = 4'h8;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int RUN_BIT  = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_HI    = 5;
  localparam int PS_LO    = 4;
  localparam int JOIN_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT  = 1;

  // writable bits per control flavour; the rest read as zero
  localparam logic [DATA_W-1:0] CTRL_MASK_SOLO = 16'hA076;
  localparam logic [DATA_W-1:0] CTRL_MASK_EVEN = 16'hA07A;
  localparam logic [DATA_W-1:0] CTRL_MASK_ODD  = 16'hA072;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [DATA_W-1:0] COUNT_RESET  = 16'h0000;
  localparam logic [PS_W-1:0]   PS_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // prescale codes and terminal counts
  // ---------------------------------------------------------------
  localparam logic [1:0]      PS_CODE_8   = 2'b01;
  localparam logic [1:0]      PS_CODE_64  = 2'b10;
  localparam logic [1:0]      PS_CODE_256 = 2'b11;
  localparam logic [PS_W-1:0] PS_LIM_1    = 8'h00;
  localparam logic [PS_W-1:0] PS_LIM_8    = 8'h07;
  localparam logic [PS_W-1:0] PS_LIM_64   = 8'h3F;
  localparam logic [PS_W-1:0] PS_LIM_256  = 8'hFF;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_INTERNAL  = 2'b00,
    SRC_GATED     = 2'b01,
    SRC_EXT_SYNC  = 2'b10,
    SRC_EXT_ASYNC = 2'b11
  } gts_src_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } gts_bus_req_t;

  typedef struct packed {
    logic [NUM_TIMERS-1:0] external_count_pin;
    logic [NUM_TIMERS-1:0] gate_pin;
  } gts_pins_t;

endpackage

/* File: hw/gts_timer_set.sv */
// standalone timer plus four joinable timer pairs with register port
`timescale 1ns/1ps
// How it works
// RULE_01: standalone 16-bit counter runs as timer, synchronous or asynchronous counter.
// RULE_02: standalone flag on period match or on gate falling edge in gated mode.
// RULE_03: control bit 15 starts counting when 1, stops it when 0.
// RULE_04: control bit 13 set halts the timer during idle; clear keeps it running.
// RULE_05: bit 6 gates accumulation only with internal clock; ignored with external.
// RULE_06: prescale field 5-4 divides by 256, 64, 8 or 1.
// RULE_07: bit 2 synchronises external clock when external selected; ignored otherwise.
// RULE_08: bit 1 picks external pin rising edges or internal instruction clock.
// RULE_09: unimplemented control bits read back as zero.
// RULE_10: each pair works as two 16-bit timers without asynchronous mode.
// RULE_11: joined pair is one 32-bit timer, flagging on 32-bit period match.
// RULE_12: joined pair ignores odd control; even control, clock, gate drive it.
// RULE_13: joined match is reported on the odd timer's flag only.
// RULE_14: odd period holds upper period word, even the lower word.
// RULE_15: odd count register holds upper count word, even the lower word.
// RULE_16: first pair triggers converter one, second pair converter two, none else.
// RULE_17: only first pair's timers are offered as capture/compare time bases.
// RULE_18: only first pair's timers raise a DMA request.
// RULE_19: every timer may keep running in idle or sleep, per idle setting.
// RULE_20: software joins, configures, loads period and enable, then runs last.
// RULE_21: software unjoins, configures, loads period and enable, then runs last.
// RULE_22: even control bit 3 joins the pair into one 32-bit timer.
// RULE_23: software clears odd idle bit for a joined pair to run in idle; the code ignores it and halts on the even idle bit.
// RULE_24: on match counter returns to zero at next count clock, flag same cycle.
module gts_timer_set
  import gts_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire gts_pkg::gts_bus_req_t        bus_req,
  output logic [gts_pkg::DATA_W-1:0]        rd_data,
  input  wire logic                         idle_mode,
  input  wire gts_pkg::gts_pins_t           pins,
  output logic [gts_pkg::NUM_TIMERS-1:0]    timer_flag,
  output logic [gts_pkg::NUM_TIMERS-1:0]    period_event,
  output logic [1:0]                        converter_trigger,
  output logic [1:0]                        dma_request,
  output logic [gts_pkg::DATA_W-1:0]        capture_base_lo,
  output logic [gts_pkg::DATA_W-1:0]        capture_base_hi
);
  import gts_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // count source from control; pairs never run asynchronously
  function automatic gts_src_t src_mode(input logic [DATA_W-1:0] c, input logic solo);
    if (!c[SRC_BIT]) begin
      return c[GATE_BIT] ? SRC_GATED : SRC_INTERNAL;        // [RULE_05] [RULE_08]
    end
    return (solo && !c[SYNC_BIT]) ? SRC_EXT_ASYNC : SRC_EXT_SYNC; // [RULE_07] [RULE_10]
  endfunction

  // prescaler terminal count per code
  function automatic logic [PS_W-1:0] ps_limit(input logic [1:0] code);
    case (code)
      PS_CODE_8:   return PS_LIM_8;                         // [RULE_06]
      PS_CODE_64:  return PS_LIM_64;
      PS_CODE_256: return PS_LIM_256;
      default:     return PS_LIM_1;
    endcase
  endfunction

  // writable bits: index 0 standalone, odd index even timer, even index odd timer
  function automatic logic [DATA_W-1:0] ctrl_mask(input int t);
    if (t == 0) begin
      return CTRL_MASK_SOLO;
    end
    return (t % 2 == 1) ? CTRL_MASK_EVEN : CTRL_MASK_ODD;   // [RULE_09]
  endfunction

  // one 16-bit count step: {match, next count}
  function automatic logic [DATA_W:0] step16(input logic [DATA_W-1:0] c,
                                             input logic [DATA_W-1:0] p,
                                             input logic              tk);
    if (!tk) begin
      return {1'b0, c};
    end
    if (c == p) begin
      return {1'b1, COUNT_RESET};                            // [RULE_24]
    end
    return {1'b0, DATA_W'(c + 16'h0001)};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]     ctrl        [NUM_TIMERS];
  logic [DATA_W-1:0]     next_ctrl   [NUM_TIMERS];
  logic [DATA_W-1:0]     period      [NUM_TIMERS];
  logic [DATA_W-1:0]     next_period [NUM_TIMERS];
  logic [DATA_W-1:0]     count       [NUM_TIMERS];
  logic [DATA_W-1:0]     next_count  [NUM_TIMERS];
  logic [PS_W-1:0]       ps          [NUM_TIMERS];
  logic [PS_W-1:0]       next_ps     [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] ext_s1, ext_s2, ext_s3, ext_stable, ext_prev;
  logic [NUM_TIMERS-1:0] next_ext_stable;
  logic [NUM_TIMERS-1:0] gate_s1, gate_s2, gate_s3, gate_stable, gate_prev;
  logic [NUM_TIMERS-1:0] next_gate_stable;
  logic [NUM_TIMERS-1:0] tick_in, tick, gate_fall;
  logic [NUM_TIMERS-1:0] next_flag, next_event;
  logic [1:0]            next_trigger;
  logic [DATA_W-1:0]     next_rd_data;

  // ---------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------
  // three-stage sync; a level is taken only once stages two and three agree
  always_comb begin
    next_ext_stable  = (~(ext_s2 ^ ext_s3) & ext_s3) | ((ext_s2 ^ ext_s3) & ext_stable);
    next_gate_stable = (~(gate_s2 ^ gate_s3) & gate_s3) | ((gate_s2 ^ gate_s3) & gate_stable);
  end

  // sync chain resets low, so a pin held high at release reads as one late rising edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_s1      <= '0;
      ext_s2      <= '0;
      ext_s3      <= '0;
      ext_stable  <= '0;
      ext_prev    <= '0;
      gate_s1     <= '0;
      gate_s2     <= '0;
      gate_s3     <= '0;
      gate_stable <= '0;
      gate_prev   <= '0;
    end else begin
      ext_s1      <= pins.external_count_pin;
      ext_s2      <= ext_s1;
      ext_s3      <= ext_s2;
      ext_stable  <= next_ext_stable;
      ext_prev    <= ext_stable;
      gate_s1     <= pins.gate_pin;
      gate_s2     <= gate_s1;
      gate_s3     <= gate_s2;
      gate_stable <= next_gate_stable;
      gate_prev   <= gate_stable;
    end
  end

  // ---------------------------------------------------------------
  // count clocks and prescalers
  // ---------------------------------------------------------------
  // with one core clock the unsynchronised path still sees the filtered pin,
  // a trade of edge latency for safety; idle halts it like any other source
  always_comb begin
    gts_src_t m;
    logic     halt;
    m    = SRC_INTERNAL;
    halt = 1'b0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      m            = src_mode(ctrl[t], t == 0);
      gate_fall[t] = (m == SRC_GATED) && ctrl[t][RUN_BIT] && gate_prev[t] && !gate_stable[t]; // [RULE_02]
      halt         = !ctrl[t][RUN_BIT]                                         // [RULE_03]
                     || (idle_mode && ctrl[t][IDLE_BIT]);                       // [RULE_04] [RULE_19]
      case (m)
        SRC_GATED:     tick_in[t] = gate_stable[t] && !halt;                   // [RULE_05]
        SRC_EXT_SYNC,
        SRC_EXT_ASYNC: tick_in[t] = ext_stable[t] && !ext_prev[t] && !halt;    // [RULE_08]
        default:       tick_in[t] = !halt;                                     // [RULE_01]
      endcase
      tick[t]    = tick_in[t] && (ps[t] == ps_limit(ctrl[t][PS_HI:PS_LO]));    // [RULE_06]
      next_ps[t] = tick_in[t] ? (tick[t] ? PS_RESET : PS_W'(ps[t] + 8'h01)) : ps[t];
      // a control or count write restarts the divide, so the first tick is a full period away
      if (bus_req.wr && bus_req.addr[5:2] == 4'(t)
          && (bus_req.addr[1:0] == REG_CTRL || bus_req.addr[1:0] == REG_COUNT)) begin
        next_ps[t] = PS_RESET;
      end
    end
  end

  // ---------------------------------------------------------------
  // counters, flags, register port
  // ---------------------------------------------------------------
  always_comb begin
    logic [DATA_W:0]     r16;
    logic [2*DATA_W-1:0] c32;
    int                  e;
    int                  o;
    r16          = '0;
    c32          = '0;
    e            = 0;
    o            = 0;
    next_event   = '0;
    next_rd_data = '0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      next_ctrl[t]   = ctrl[t];
      next_period[t] = period[t];
      next_count[t]  = count[t];
    end
    // standalone timer
    r16           = step16(count[0], period[0], tick[0]);
    next_count[0] = r16[DATA_W-1:0];
    next_event[0] = r16[DATA_W] || gate_fall[0];                               // [RULE_02]
    // pairs
    for (int p = 0; p < NUM_PAIRS; p++) begin
      e = 2 * p + 1;
      o = 2 * p + 2;
      if (ctrl[e][JOIN_BIT]) begin                                             // [RULE_22]
        // odd control, clock and gate are not looked at here
        c32 = {count[o], count[e]};                                            // [RULE_15]
        if (tick[e]) begin                                                     // [RULE_12]
          if (c32 == {period[o], period[e]}) begin                             // [RULE_14] [RULE_11]
            c32           = '0;
            next_event[o] = 1'b1;                                              // [RULE_13]
          end else begin
            c32 = 32'(c32 + 32'h0000_0001);
          end
        end
        // the even gate drives the joined pair, its falling edge lands on the odd flag
        next_event[o] = next_event[o] || gate_fall[e];
        next_count[e] = c32[DATA_W-1:0];
        next_count[o] = c32[2*DATA_W-1:DATA_W];
      end else begin
        r16           = step16(count[e], period[e], tick[e]);                  // [RULE_10]
        next_count[e] = r16[DATA_W-1:0];
        next_event[e] = r16[DATA_W] || gate_fall[e];
        r16           = step16(count[o], period[o], tick[o]);
        next_count[o] = r16[DATA_W-1:0];
        next_event[o] = r16[DATA_W] || gate_fall[o];
      end
    end
    // software writes win over the count step in the same cycle
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (bus_req.wr && bus_req.addr[5:2] == 4'(t)) begin
        case (bus_req.addr[1:0])
          REG_CTRL:   next_ctrl[t]   = bus_req.wdata & ctrl_mask(t);           // [RULE_09]
          REG_PERIOD: next_period[t] = bus_req.wdata;
          REG_COUNT:  next_count[t]  = bus_req.wdata;
          default:    next_count[t]  = next_count[t];
        endcase
      end
      // reads show the value before this edge's write; unmapped places read zero
      if (bus_req.rd && bus_req.addr[5:2] == 4'(t)) begin
        case (bus_req.addr[1:0])
          REG_CTRL:   next_rd_data = ctrl[t];
          REG_PERIOD: next_rd_data = period[t];
          REG_COUNT:  next_rd_data = count[t];
          default:    next_rd_data = '0;
        endcase
      end
    end
    // status word gathers every sticky flag in timer index order
    if (bus_req.rd && bus_req.addr == STATUS_ADDR) begin
      next_rd_data = {{(DATA_W-NUM_TIMERS){1'b0}}, timer_flag};
    end
    // sticky flags: write one to clear, a new event in the same cycle wins
    next_flag = timer_flag & ~((bus_req.wr && bus_req.addr == STATUS_ADDR)
                               ? bus_req.wdata[NUM_TIMERS-1:0] : '0);
    next_flag = next_flag | next_event;
    // converter triggers from the first two pairs only
    next_trigger[0] = ctrl[1][JOIN_BIT] ? next_event[2] : next_event[1];       // [RULE_16]
    next_trigger[1] = ctrl[3][JOIN_BIT] ? next_event[4] : next_event[3];
  end

  // one register bank for every timer; reset clears counts and arms periods at all ones
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        ctrl[t]   <= CTRL_RESET;
        period[t] <= PERIOD_RESET;
        count[t]  <= COUNT_RESET;
        ps[t]     <= PS_RESET;
      end
      timer_flag        <= '0;
      period_event      <= '0;
      converter_trigger <= '0;
      rd_data           <= '0;
    end else begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        ctrl[t]   <= next_ctrl[t];
        period[t] <= next_period[t];
        count[t]  <= next_count[t];
        ps[t]     <= next_ps[t];
      end
      timer_flag        <= next_flag;
      period_event      <= next_event;
      converter_trigger <= next_trigger;
      rd_data           <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // side outputs of the first pair
  // ---------------------------------------------------------------
  // the other pairs have no time base or dma path at all
  // dma requests follow the events, so a joined pair asks only on odd events: the 32-bit match or the even gate fall
  assign capture_base_lo = count[1];                                           // [RULE_17]
  assign capture_base_hi = count[2];
  assign dma_request     = {period_event[2], period_event[1]};                 // [RULE_18]

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // all checks run on the core clock and rest during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // these watch design state and the bus request and idle inputs that the bench drives

  solo_ctrl_read_a: assert property (bus_req.rd && bus_req.addr == 6'h00  // [RULE_09]
    |=> (rd_data & ~CTRL_MASK_SOLO) == '0) else $error("reserved control bits read nonzero");

  stopped_hold_a: assert property (!ctrl[0][RUN_BIT] && !bus_req.wr  // [RULE_03]
    |=> count[0] == $past(count[0])) else $error("stopped timer moved");

  idle_halt_a: assert property (idle_mode && ctrl[0][IDLE_BIT] && ctrl[0][RUN_BIT]  // [RULE_04]
    |-> !tick_in[0]) else $error("timer counted in idle");

  match_wrap_a: assert property (tick[0] && count[0] == period[0] && !bus_req.wr  // [RULE_24]
    |=> count[0] == '0 && timer_flag[0] && period_event[0]) else $error("no wrap on match");

  prescale_term_a: assert property (tick[0] |-> ps[0] == ps_limit(ctrl[0][PS_HI:PS_LO])  // [RULE_06]
    ##1 ps[0] == PS_RESET) else $error("prescaler tick at wrong count");

  ext_gate_ignore_a: assert property (ctrl[0][SRC_BIT] && ctrl[0][GATE_BIT] && ctrl[0][RUN_BIT]  // [RULE_05]
    && !idle_mode && !(ext_stable[0] && !ext_prev[0]) |-> !tick_in[0]) else $error("gate used with ext clock");

  wrap32_a: assert property (ctrl[1][JOIN_BIT] && tick[1] && !bus_req.wr  // [RULE_11]
    && {count[2], count[1]} == {period[2], period[1]}
    |=> count[1] == '0 && count[2] == '0 && period_event[2] && !period_event[1])
    else $error("32-bit match not reported on odd flag");

  carry32_a: assert property (ctrl[1][JOIN_BIT] && tick[1] && !bus_req.wr  // [RULE_15]
    && count[1] == 16'hFFFF && {count[2], count[1]} != {period[2], period[1]}
    |=> count[1] == '0 && count[2] == $past(count[2]) + 16'h0001) else $error("upper word missed carry");

  trigger_src_a: assert property (converter_trigger[0]  // [RULE_16]
    |-> period_event[1] || period_event[2]) else $error("converter trigger without pair event");

  gate_event_a: assert property (ctrl[0][RUN_BIT] && ctrl[0][GATE_BIT] && !ctrl[0][SRC_BIT]  // [RULE_02]
    && gate_prev[0] && !gate_stable[0] |=> period_event[0] && timer_flag[0])
    else $error("gate falling edge gave no event");

  odd_ignored_a: assert property (ctrl[1][JOIN_BIT] && !ctrl[1][RUN_BIT] && !bus_req.wr  // [RULE_12]
    |=> count[2] == $past(count[2]) && !period_event[2]) else $error("odd timer moved in stopped pair");

  second_trigger_a: assert property (converter_trigger[1]  // [RULE_16]
    |-> period_event[3] || period_event[4]) else $error("second trigger without pair event");

endmodule

/* File: verification/gts_timer_set_tb.sv */
// self-checking bench for the general timer set
`timescale 1ns/1ps
module gts_timer_set_tb;
  import gts_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int TMO = 20000;  // cycle ceiling, the run needs well under half of it
  logic                  core_clk;
  logic                  sys_rst;
  gts_bus_req_t          bus_req;
  logic [DATA_W-1:0]     rd_data;
  logic                  idle_mode;
  gts_pins_t             pins;
  logic [NUM_TIMERS-1:0] timer_flag;
  logic [NUM_TIMERS-1:0] period_event;
  logic [1:0]            converter_trigger;
  logic [1:0]            dma_request;
  logic [DATA_W-1:0]     capture_base_lo;
  logic [DATA_W-1:0]     capture_base_hi;
  logic [DATA_W-1:0]     exp_q[$];
  logic                  rd_d;
  logic [1:0]            seen_conv;
  logic [1:0]            seen_dma;
  logic                  found;
  logic [DATA_W-1:0]     rv;
  int                    err_total;
  int                    checks_done;
  int                    cyc;
  int                    seed;
  int                    n;
  int                    per;
  int                    div;

  gts_timer_set i_dut (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .bus_req           (bus_req),
    .rd_data           (rd_data),
    .idle_mode         (idle_mode),
    .pins              (pins),
    .timer_flag        (timer_flag),
    .period_event      (period_event),
    .converter_trigger (converter_trigger),
    .dma_request       (dma_request),
    .capture_base_lo   (capture_base_lo),
    .capture_base_hi   (capture_base_hi)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] ra(input int t, input logic [1:0] r);
    return {t[3:0], r};
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // strobe is dropped one edge later, so back-to-back calls never reassign it in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge core_clk);
    bus_req.wr    <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge core_clk);
    bus_req.rd   <= 1'b0;
    @(posedge core_clk);
  endtask

  // bounded wait for a one-cycle period_event pulse, match or gate fall; n holds the cycles spent
  task automatic wait_evt(input int t, input int bound);
    n     = 0;
    found = 1'b0;
    while (n < bound && !found) begin
      @(posedge core_clk);
      n++;
      found = (period_event[t] === 1'b1);
    end
  endtask

  task automatic pulse_ext(input int k);
    repeat (k) begin
      pins.external_count_pin[0] <= 1'b1;
      repeat (6) @(posedge core_clk);
      pins.external_count_pin[0] <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask

  // ---------------------------------------------------------------
  // clock, monitor, timeout
  // ---------------------------------------------------------------
  always #5 core_clk = ~core_clk;

  // read data stands only the cycle after the strobe; blocking or keeps clears race-free
  always @(posedge core_clk) begin
    if (rd_d)
      check(rd_data, exp_q.pop_front());
    rd_d      <= bus_req.rd;
    seen_conv = seen_conv | converter_trigger;
    seen_dma  = seen_dma | dma_request;
    cyc++;
    if (cyc == TMO) begin
      err_total++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 24; err_total = 0; checks_done = 0; cyc = 0; rd_d = 1'b0;
    core_clk = 1'b0; sys_rst = 1'b1; bus_req = '0; idle_mode = 1'b0; pins = '0;
    seen_conv = 2'b00; seen_dma = 2'b00;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    // reset values, writable masks, unmapped places
    rd(ra(0, REG_CTRL), CTRL_RESET);
    rd(ra(0, REG_PERIOD), PERIOD_RESET);
    rd(ra(0, REG_COUNT), COUNT_RESET);
    for (int t = 0; t < NUM_TIMERS; t++) begin
      wr(ra(t, REG_CTRL), 16'hFFFF);
      rd(ra(t, REG_CTRL), (t == 0) ? CTRL_MASK_SOLO : (t % 2) ? CTRL_MASK_EVEN : CTRL_MASK_ODD);
      wr(ra(t, REG_CTRL), 16'h0000);
    end
    wr(6'h3F, 16'h1234);
    rd(6'h3F, 16'h0000);
    rd(6'h03, 16'h0000);
    wr(STATUS_ADDR, 16'h01FF);
    // every prescale code, random short periods; gap between matches is exact
    for (int c = 0; c < 4; c++) begin
      per = 1 + ($unsigned($random(seed)) % 4);
      div = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
      wr(ra(0, REG_CTRL), 16'h0000);
      wr(ra(0, REG_COUNT), 16'h0000);
      wr(ra(0, REG_PERIOD), 16'(per));
      wr(ra(0, REG_CTRL), 16'h8000 | 16'(c << PS_LO));
      wait_evt(0, 2 * (per + 1) * div + 8);
      check(16'(found), 16'h0001);
      wait_evt(0, 2 * (per + 1) * div + 8);
      check(16'(n), 16'((per + 1) * div));
    end
    // sticky flag holds after stop until cleared
    wr(ra(0, REG_CTRL), 16'h0000);
    check(16'(timer_flag[0]), 16'h0001);
    wr(STATUS_ADDR, 16'h0001);
    check(16'(timer_flag[0]), 16'h0000);
    // run control and idle halt
    wr(ra(0, REG_PERIOD), 16'h0003);
    wait_evt(0, 30);
    check(16'(found), 16'h0000);
    idle_mode <= 1'b1;
    wr(ra(0, REG_CTRL), 16'hA000);
    wait_evt(0, 30);
    check(16'(found), 16'h0000);
    wr(ra(0, REG_CTRL), 16'h8000);
    wait_evt(0, 30);
    check(16'(found), 16'h0001);
    idle_mode <= 1'b0;
    wr(ra(0, REG_CTRL), 16'hA000);
    wait_evt(0, 30);
    check(16'(found), 16'h0001);
    // external pin: synced with gate bit set (ignored), then unsynced during idle
    for (int m = 0; m < 2; m++) begin
      wr(ra(0, REG_CTRL), 16'h0000);
      wr(ra(0, REG_COUNT), 16'h0000);
      wr(ra(0, REG_PERIOD), 16'hFFFF);
      idle_mode <= m[0];
      wr(ra(0, REG_CTRL), (m == 0) ? 16'h8046 : 16'h8002);
      per = 3 + ($unsigned($random(seed)) % 5);
      pulse_ext(per);
      wr(ra(0, REG_CTRL), 16'h0000);
      rd(ra(0, REG_COUNT), 16'(per));
    end
    idle_mode <= 1'b0;
    // gated accumulation: falling gate edge raises the event
    wr(ra(0, REG_COUNT), 16'h0000);
    wr(ra(0, REG_CTRL), 16'h8040);
    wait_evt(0, 20);
    check(16'(found), 16'h0000);
    pins.gate_pin[0] <= 1'b1;
    repeat (20) @(posedge core_clk);
    pins.gate_pin[0] <= 1'b0;
    wait_evt(0, 12);
    check(16'(found), 16'h0001);
    wr(ra(0, REG_CTRL), 16'h0000);
    // joined pair 1/2: upper period word must matter, odd control stays stopped
    wr(STATUS_ADDR, 16'h01FF);
    for (int h = 2; h > 0; h--) begin
      wr(ra(1, REG_CTRL), 16'h0008);
      wr(ra(1, REG_PERIOD), 16'h0002);
      wr(ra(2, REG_PERIOD), 16'(h));
      wr(ra(1, REG_COUNT), 16'hFFF0);
      wr(ra(2, REG_COUNT), 16'h0000);
      wr(ra(2, REG_CTRL), 16'h0000);
      seen_conv = 2'b00;
      seen_dma  = 2'b00;
      wr(ra(1, REG_CTRL), 16'h8008);
      wait_evt(2, 40);
      check(16'(found), 16'(h == 1));
    end
    wr(ra(1, REG_CTRL), 16'h0008);
    check(16'(timer_flag[2:1]), 16'h0002);
    rd(STATUS_ADDR, 16'h0004);
    check(16'(seen_conv), 16'h0001);
    check(16'(seen_dma), 16'h0002);
    // carry into the upper count word, then the capture time bases
    wr(ra(1, REG_PERIOD), 16'hFFFF);
    wr(ra(2, REG_PERIOD), 16'hFFFF);
    wr(ra(1, REG_COUNT), 16'hFFFE);
    wr(ra(2, REG_COUNT), 16'h0000);
    wr(ra(1, REG_CTRL), 16'h8008);
    repeat (6) @(posedge core_clk);
    wr(ra(1, REG_CTRL), 16'h0008);
    rd(ra(2, REG_COUNT), 16'h0001);
    rv = 16'($random(seed));
    wr(ra(1, REG_COUNT), rv);
    check(capture_base_lo, rv);
    check(capture_base_hi, 16'h0001);
    // each pair timer alone: trigger and dma only where the pair allows
    wr(ra(1, REG_CTRL), 16'h0000);
    for (int t = 1; t < NUM_TIMERS; t++) begin
      wr(ra(t, REG_COUNT), 16'h0000);
      wr(ra(t, REG_PERIOD), 16'h0003);
      seen_conv = 2'b00;
      seen_dma  = 2'b00;
      wr(ra(t, REG_CTRL), 16'h8000);
      wait_evt(t, 30);
      wr(ra(t, REG_CTRL), 16'h0000);
      check(16'(found), 16'h0001);
      check(16'(seen_conv), 16'((t == 1) ? 1 : (t == 3) ? 2 : 0));
      check(16'(seen_dma), 16'((t == 1) ? 1 : (t == 2) ? 2 : 0));
    end
    wrap_up();
  end
endmodule
